// [dspwm_core.sv]
// phase and frequency correct dual slope pwm timer with register port
//
// Behaviour
// - modes 8/9 count 0 up to top, down
// - noninverting: clear on up match, set down
// - top from capture reg (8) or compare a (9)
// - counter stays at top for one tick
// - compare writes buffered, loaded at bottom
// - overflow flag set in the load tick
// - compare a or capture flag at top
// - compare flag set on counter equal compare
// - action 10 noninverted, 11 inverted pwm
// - pin driven only when direction bit set
// - tick from divider 1/8/64/256/1024
// - noninverting: compare zero low, compare top high
// - mode 9 action 01 toggles channel a
// - all logic on one clock, tick enables
// - mode select split over two controls
// - actions 10/11, and 01 on channel a in mode 9, take over pin function
// - action 01 leaves channel b disconnected
`timescale 1ns/10ps
module dspwm_core
    import dspwm_pkg::*;
(
    input  wire logic                         i_clock,
    input  wire logic                         i_rst,
    input  wire logic [dspwm_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [dspwm_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                         i_wr,
    input  wire logic                         i_rd,
    input  wire logic                         i_port_a,
    input  wire logic                         i_port_b,
    output logic      [dspwm_pkg::DATA_W-1:0] o_rdata,
    output logic                              o_pin_a,
    output logic                              o_pin_a_oe,
    output logic                              o_pin_b,
    output logic                              o_pin_b_oe
);
    import dspwm_pkg::*;

    typedef struct packed {
        logic [7:0]                    ctrl_a;
        logic [4:0]                    ctrl_b;
        logic [CNT_W-1:0]              cnt;
        dspwm_dir_t                    dir;
        logic [NUM_CH-1:0][CNT_W-1:0]  cmp_buf;
        logic [NUM_CH-1:0][CNT_W-1:0]  cmp;
        logic [CNT_W-1:0]              cap_top;
        logic [3:0]                    flags;
        logic [NUM_CH-1:0]             dir_bits;
        logic [PRE_W-1:0]              pre;
        logic                          tick;
        logic [NUM_CH-1:0]             oc;
        logic [NUM_CH-1:0]             pin;
        logic [NUM_CH-1:0]             pin_oe;
        logic [DATA_W-1:0]             rdata;
    } dspwm_state_t;

    dspwm_state_t s_q;
    dspwm_state_t s_d;

    logic [3:0]       mode;
    logic             pfc;
    logic [CNT_W-1:0] top;
    logic [PRE_W-1:0] div_m1;
    logic             pre_run;
    logic             step;
    logic             eff_up;
    logic [1:0]       act;
    logic             tog;
    logic [NUM_CH-1:0] port_in;

    assign port_in = {i_port_b, i_port_a};

    // derived mode, top and prescaler selection
    always_comb
    begin
        mode   = {s_q.ctrl_b[MODE_HI_LSB +: 2], s_q.ctrl_a[MODE_LO_LSB +: 2]};
        pfc    = (mode == MODE_CAP_TOP) || (mode == MODE_CMPA_TOP);
        top    = (mode == MODE_CMPA_TOP) ? s_q.cmp[0] : s_q.cap_top;
        step   = s_q.tick && pfc;
        // bottom counts as upcount and top as downcount, so 0 and top give flat levels
        eff_up = (s_q.cnt == BOTTOM) || ((s_q.dir == DSPWM_UP) && (s_q.cnt != top));
        pre_run = 1'b1;
        case (s_q.ctrl_b[PRE_LSB +: 3])
            PRE_1:    div_m1 = DIV1_M1;
            PRE_8:    div_m1 = DIV8_M1;
            PRE_64:   div_m1 = DIV64_M1;
            PRE_256:  div_m1 = DIV256_M1;
            PRE_1024: div_m1 = DIV1024_M1;
            default:
            begin
                div_m1  = DIV1_M1;
                pre_run = 1'b0;
            end
        endcase
    end

    // next state of the whole block
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = '0;
        act       = ACT_OFF;
        tog       = 1'b0;

        // prescaler: a stopped clock source simply never ticks; >= so a smaller divisor
        // chosen mid-count does not have to wrap the whole divider first
        if (!pre_run || (s_q.pre >= div_m1))
            s_d.pre = '0;
        else
            s_d.pre = s_q.pre + 10'h001;
        s_d.tick = pre_run && (s_q.pre >= div_m1);

        // software flag clear first, so a same-cycle hardware set wins
        if (i_wr && (i_addr == ADR_FLAGS))
            s_d.flags = s_q.flags & ~i_wdata[3:0];

        // dual slope counter
        if (step)
        begin
            case (s_q.dir)
                DSPWM_UP:
                begin
                    if (s_q.cnt >= top)
                    begin
                        s_d.dir = DSPWM_DOWN;
                        s_d.cnt = s_q.cnt - 16'h0001;
                        if (mode == MODE_CAP_TOP)
                            s_d.flags[FLG_CAP] = 1'b1;
                        else
                            s_d.flags[FLG_CMP0] = 1'b1;
                    end
                    else
                        s_d.cnt = s_q.cnt + 16'h0001;
                end
                DSPWM_DOWN:
                begin
                    if (s_q.cnt == BOTTOM)
                    begin
                        s_d.dir = DSPWM_UP;
                        s_d.cnt = s_q.cnt + 16'h0001;
                        s_d.cmp = s_q.cmp_buf;
                        s_d.flags[FLG_OVF] = 1'b1;
                    end
                    else
                        s_d.cnt = s_q.cnt - 16'h0001;
                end
                default: s_d.dir = DSPWM_UP;
            endcase
        end

        // per channel compare match, output action and pin mux
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            act = (ch == 0) ? s_q.ctrl_a[ACT_A_LSB +: 2] : s_q.ctrl_a[ACT_B_LSB +: 2];
            // toggle only exists on channel a with compare a as top
            tog = (act == ACT_TOGGLE) && (ch == 0) && (mode == MODE_CMPA_TOP);
            if (step && (s_q.cnt == s_q.cmp[ch]))
            begin
                s_d.flags[FLG_CMP0 + ch] = 1'b1;
                case (act)
                    ACT_NONINV: s_d.oc[ch] = !eff_up;
                    ACT_INV:    s_d.oc[ch] = eff_up;
                    ACT_TOGGLE: s_d.oc[ch] = tog ? !s_q.oc[ch] : s_q.oc[ch];
                    default:    s_d.oc[ch] = s_q.oc[ch];
                endcase
            end
            if ((act == ACT_NONINV) || (act == ACT_INV) || tog)
                s_d.pin[ch] = s_q.oc[ch];
            else
                s_d.pin[ch] = port_in[ch];
            s_d.pin_oe[ch] = s_q.dir_bits[ch];
        end

        // register writes; a counter write overrides the count step
        if (i_wr)
        begin
            case (i_addr)
                ADR_CTRL_A: s_d.ctrl_a = i_wdata[7:0] & CTRL_A_MASK;
                ADR_CTRL_B: s_d.ctrl_b = i_wdata[4:0];
                ADR_COUNT:  s_d.cnt = i_wdata;
                ADR_CMP_A:  s_d.cmp_buf[0] = i_wdata;
                ADR_CMP_B:  s_d.cmp_buf[1] = i_wdata;
                ADR_CAPTOP: s_d.cap_top = i_wdata;
                ADR_DIR:    s_d.dir_bits = i_wdata[NUM_CH-1:0];
                default:    s_d.ctrl_a = s_d.ctrl_a;
            endcase
        end

        // read data valid only in the cycle after the strobe
        if (i_rd)
        begin
            case (i_addr)
                ADR_CTRL_A: s_d.rdata = {8'h00, s_q.ctrl_a};
                ADR_CTRL_B: s_d.rdata = {11'h000, s_q.ctrl_b};
                ADR_COUNT:  s_d.rdata = s_q.cnt;
                ADR_CMP_A:  s_d.rdata = s_q.cmp_buf[0];
                ADR_CMP_B:  s_d.rdata = s_q.cmp_buf[1];
                ADR_CAPTOP: s_d.rdata = s_q.cap_top;
                ADR_FLAGS:  s_d.rdata = {12'h000, s_q.flags};
                ADR_DIR:    s_d.rdata = {14'h0000, s_q.dir_bits};
                default:    s_d.rdata = '0;
            endcase
        end
    end

    // state register; counting down at reset makes the first tick a bottom load
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q     <= '0;
            s_q.dir <= DSPWM_DOWN;
        end
        else
            s_q <= s_d;
    end

    assign o_rdata    = s_q.rdata;
    assign o_pin_a    = s_q.pin[0];
    assign o_pin_a_oe = s_q.pin_oe[0];
    assign o_pin_b    = s_q.pin[1];
    assign o_pin_b_oe = s_q.pin_oe[1];

    // checks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence up_mid_s;
        step && (s_q.dir == DSPWM_UP) && (s_q.cnt < top) && !i_wr;
    endsequence

    sequence bottom_s;
        step && (s_q.dir == DSPWM_DOWN) && (s_q.cnt == BOTTOM) && !i_wr;
    endsequence

    sequence a_up_match_s;
        step && (s_q.ctrl_a[ACT_A_LSB +: 2] == ACT_NONINV) && (s_q.dir == DSPWM_UP)
            && (s_q.cnt == s_q.cmp[0]) && (s_q.cnt != BOTTOM) && (s_q.cnt != top) && !i_wr;
    endsequence

    count_up_a: assert property (up_mid_s |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("counter did not increment on upslope");

    top_turn_a: assert property (
        step && (s_q.dir == DSPWM_UP) && (s_q.cnt == top) && !i_wr
        |=> (s_q.dir == DSPWM_DOWN) && (s_q.cnt == $past(s_q.cnt) - 16'h0001))
        else $error("counter did not turn after one tick at top");

    bottom_load_a: assert property (
        bottom_s |=> (s_q.cmp == $past(s_q.cmp_buf)) && (s_q.dir == DSPWM_UP))
        else $error("compare buffers not loaded at bottom");

    overflow_set_a: assert property (bottom_s |=> s_q.flags[FLG_OVF])
        else $error("overflow flag missing at bottom");

    match_flag_a: assert property (step && (s_q.cnt == s_q.cmp[1]) |=> s_q.flags[FLG_CMP0 + 1])
        else $error("compare b flag missing on match");

    cap_flag_a: assert property (
        step && (mode == MODE_CAP_TOP) && (s_q.dir == DSPWM_UP) && (s_q.cnt == top)
        |=> s_q.flags[FLG_CAP])
        else $error("capture flag missing at top");

    noninv_clear_a: assert property (a_up_match_s |=> !s_q.oc[0] ##1 !o_pin_a)
        else $error("noninverted output not cleared on upcount match");

    pin_enable_a: assert property (o_pin_b_oe == $past(s_q.dir_bits[1]))
        else $error("pin b enable does not follow direction bit");

    toggle_a_a: assert property (
        step && (mode == MODE_CMPA_TOP) && (s_q.ctrl_a[ACT_A_LSB +: 2] == ACT_TOGGLE)
        && (s_q.cnt == s_q.cmp[0]) |=> s_q.oc[0] != $past(s_q.oc[0]))
        else $error("channel a did not toggle on match");

    prescale_gap_a: assert property (
        s_q.tick && (s_q.ctrl_b[PRE_LSB +: 3] == PRE_8) && !i_wr |=> (!s_q.tick)[*7])
        else $error("divide by 8 ticked early");
endmodule

// [dspwm_pkg.sv]
// shared constants for the dual slope pwm block
package dspwm_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int CNT_W  = 16;
    localparam int PRE_W  = 10;
    localparam int NUM_CH = 2;

    // register offsets
    localparam logic [ADDR_W-1:0] ADR_CTRL_A = 4'h0;
    localparam logic [ADDR_W-1:0] ADR_CTRL_B = 4'h1;
    localparam logic [ADDR_W-1:0] ADR_COUNT  = 4'h2;
    localparam logic [ADDR_W-1:0] ADR_CMP_A  = 4'h3;
    localparam logic [ADDR_W-1:0] ADR_CMP_B  = 4'h4;
    localparam logic [ADDR_W-1:0] ADR_CAPTOP = 4'h5;
    localparam logic [ADDR_W-1:0] ADR_FLAGS  = 4'h6;
    localparam logic [ADDR_W-1:0] ADR_DIR    = 4'h7;

    // field positions
    localparam int ACT_A_LSB   = 6;
    localparam int ACT_B_LSB   = 4;
    localparam int MODE_LO_LSB = 0;
    localparam int MODE_HI_LSB = 3;
    localparam int PRE_LSB     = 0;
    localparam int FLG_OVF     = 0;
    localparam int FLG_CMP0    = 1;
    localparam int FLG_CAP     = 3;
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;

    // waveform modes and output actions
    localparam logic [3:0] MODE_CAP_TOP  = 4'h8;
    localparam logic [3:0] MODE_CMPA_TOP = 4'h9;
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV    = 2'h3;

    // prescaler selects and divide-minus-one counts
    localparam logic [2:0] PRE_1    = 3'h1;
    localparam logic [2:0] PRE_8    = 3'h2;
    localparam logic [2:0] PRE_64   = 3'h3;
    localparam logic [2:0] PRE_256  = 3'h4;
    localparam logic [2:0] PRE_1024 = 3'h5;
    localparam logic [PRE_W-1:0] DIV1_M1    = 10'h000;
    localparam logic [PRE_W-1:0] DIV8_M1    = 10'h007;
    localparam logic [PRE_W-1:0] DIV64_M1   = 10'h03f;
    localparam logic [PRE_W-1:0] DIV256_M1  = 10'h0ff;
    localparam logic [PRE_W-1:0] DIV1024_M1 = 10'h3ff;

    localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;

    typedef enum logic {DSPWM_UP = 1'b0, DSPWM_DOWN = 1'b1} dspwm_dir_t;
endpackage

// [dspwm_load.sv]
// load model standing on one pwm pin, measuring high time and rising edges
`timescale 1ns/10ps
module dspwm_load
(
    input  wire logic        i_clock,
    input  wire logic        i_pin,
    input  wire logic        i_oe,
    input  wire logic        i_meas,
    output logic      [31:0] o_high,
    output logic      [31:0] o_rise
);
    logic        level;
    logic        prev_q = 1'b0;
    logic [31:0] high_q = 32'h0;
    logic [31:0] rise_q = 32'h0;

    // an undriven pin is pulled low by the load, so a stale level never counts
    assign level  = i_oe ? i_pin : 1'b0;
    assign o_high = high_q;
    assign o_rise = rise_q;

    // counters only run inside a measuring window; prev always tracks the wire
    always @(posedge i_clock)
    begin
        prev_q <= level;
        if (i_meas)
        begin
            high_q <= high_q + {31'h0, level};
            rise_q <= rise_q + {31'h0, level & ~prev_q};
        end
    end
endmodule

// [dspwm_core_test.sv]
// self-checking bench for the dual slope pwm timer
`timescale 1ns/10ps
`define CHK(g, e) \
    begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dspwm_core_test;
    import dspwm_pkg::*;
    typedef struct {logic [3:0] mode; logic [2:0] psel; int n; logic [1:0] aa, ab;
        logic [15:0] ca, cb, cap; int top, hia, hib, rb; logic [3:0] flg; logic pb;} dspwm_case_t;
    logic        i_clock = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, meas = 1'b0;
    logic        i_port_a = 1'b0, i_port_b = 1'b0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic        o_pin_a, o_pin_a_oe, o_pin_b, o_pin_b_oe;
    logic [31:0] hi_a, hi_b, rise_a, rise_b;
    int          checked = 0, n_mismatch = 0, k;
    dspwm_case_t cases [0:4];

    dspwm_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .i_port_a(i_port_a), .i_port_b(i_port_b), .o_rdata(o_rdata), .o_pin_a(o_pin_a),
        .o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b), .o_pin_b_oe(o_pin_b_oe));
    dspwm_load load_a (.i_clock(i_clock), .i_pin(o_pin_a), .i_oe(o_pin_a_oe), .i_meas(meas),
        .o_high(hi_a), .o_rise(rise_a));
    dspwm_load load_b (.i_clock(i_clock), .i_pin(o_pin_b), .i_oe(o_pin_b_oe), .i_meas(meas),
        .o_high(hi_b), .o_rise(rise_b));

    // 100 MHz clock
    always #5 i_clock = ~i_clock;

    // one-cycle write strobe
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task rchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, e)
    endtask

    // back-to-back count reads; each step must be one, turning at both ends
    task seq_check(input int top);
        logic [15:0] v [0:13];
        logic        ok;
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= ADR_COUNT;
        for (int i = 0; i < 14; i++)
        begin
            @(posedge i_clock);
            // drop the strobe at the edge that takes the last read
            if (i == 13)
                i_rd <= 1'b0;
            #1 v[i] = o_rdata;
        end
        for (int i = 1; i < 13; i++)
        begin
            ok = (v[i] <= top) && ((v[i+1] == v[i] + 16'h1) || (v[i] == v[i+1] + 16'h1));
            `CHK(ok, 1'b1)
            if (v[i] == top) `CHK({v[i-1], v[i+1]}, {16'(top - 1), 16'(top - 1)})
            if (v[i] == 16'h0000) `CHK(v[i+1], 16'h0001)
        end
    endtask

    // configure, let three periods settle, measure two periods, stop and check flags
    task run(input dspwm_case_t c);
        logic [31:0] ha, hb, rb;
        int          per;
        per = 2 * c.n * c.top;
        wr(ADR_CMP_A, c.ca);
        wr(ADR_CMP_B, c.cb);
        wr(ADR_CAPTOP, c.cap);
        i_port_b <= c.pb;
        wr(ADR_CTRL_A, {8'h00, c.aa, c.ab, 2'b00, c.mode[1:0]});
        wr(ADR_CTRL_B, {11'h000, c.mode[3:2], c.psel});
        // three periods cover a leftover slope of the previous case plus the first buffer load
        repeat (3 * per) @(posedge i_clock);
        // flags raised by that transient with stale compares are not this case's result
        wr(ADR_FLAGS, 16'h000f);
        if (c.n == 1) seq_check(c.top);
        #1;
        ha = hi_a;
        hb = hi_b;
        rb = rise_b;
        meas <= 1'b1;
        repeat (2 * per) @(posedge i_clock);
        meas <= 1'b0;
        #1;
        `CHK(hi_a - ha, 32'(c.hia * c.n))
        `CHK(hi_b - hb, 32'(c.hib * c.n))
        `CHK(rise_b - rb, 32'(c.rb))
        wr(ADR_CTRL_B, {11'h000, c.mode[3:2], 3'h0});
        rchk(ADR_FLAGS, {12'h000, c.flg});
        wr(ADR_FLAGS, 16'h000f);
        rchk(ADR_FLAGS, 16'h0000);
    endtask

    task results;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog well beyond the longest case sequence
    initial
    begin
        repeat (60000) @(posedge i_clock);
        n_mismatch++;
        results;
    end

    // main sequence; tops stay at least 3 and not below any compare except case 3 channel b
    initial
    begin
        cases[0] = '{MODE_CAP_TOP, PRE_1, 1, ACT_NONINV, ACT_NONINV, 16'h0, 16'h2, 16'h5, 5, 0, 8, 2, 4'hf, 1'b0};
        cases[1] = '{MODE_CAP_TOP, PRE_8, 8, ACT_INV, ACT_INV, 16'h5, 16'h2, 16'h5, 5, 0, 12, 2, 4'hf, 1'b0};
        cases[2] = '{MODE_CMPA_TOP, PRE_64, 64, ACT_TOGGLE, ACT_NONINV, 16'h3, 16'h3, 16'h0, 3, 6, 12, 0, 4'h7, 1'b0};
        cases[3] = '{MODE_CAP_TOP, PRE_256, 256, ACT_NONINV, ACT_OFF, 16'h1, 16'h5, 16'h3, 3, 4, 12, 0, 4'hb, 1'b1};
        cases[4] = '{MODE_CMPA_TOP, PRE_1024, 1024, ACT_NONINV, ACT_TOGGLE, 16'h3, 16'h1, 16'h0, 3, 12, 0, 0, 4'h7,
            1'b0};
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        rchk(ADR_CTRL_A, 16'h0000);
        rchk(ADR_COUNT, 16'h0000);
        rchk(ADR_FLAGS, 16'h0000);
        rchk(ADR_DIR, 16'h0000);
        wr(4'h8, 16'hffff);
        rchk(4'h8, 16'h0000);
        wr(ADR_CTRL_A, 16'hffff);
        rchk(ADR_CTRL_A, {8'h00, CTRL_A_MASK});
        wr(ADR_CTRL_A, 16'h0000);
        wr(ADR_DIR, 16'h0003);
        repeat (2) @(posedge i_clock);
        #1;
        `CHK({o_pin_a_oe, o_pin_b_oe}, 2'b11)
        for (k = 0; k < 5; k++)
            run(cases[k]);
        wr(ADR_DIR, 16'h0000);
        repeat (3) @(posedge i_clock);
        #1;
        `CHK({o_pin_a_oe, o_pin_b_oe}, 2'b00)
        results;
    end
endmodule
